/* File: pkg/trc_cfg.svh */
// offsets, field positions, reset values and timing counts
`ifndef TRC_CFG_SVH
`define TRC_CFG_SVH

// apb register byte offsets
`define TRC_ADDR_W        8
`define TRC_OFS_BUSST     8'h00
`define TRC_OFS_CMD       8'h04
`define TRC_OFS_STAT      8'h08

// busst fields, read/write
`define TRC_BUS_REMOTE    0
`define TRC_BUS_LISTENER_LAMP    1
`define TRC_BUS_TALKER_LAMP      2
`define TRC_BUS_SRQ       3
`define TRC_BUS_LOCKOUT   4

// cmd fields, write pulses; also front-panel key index
`define TRC_CMD_RX        0
`define TRC_CMD_TX        1
`define TRC_CMD_TAP_A     2
`define TRC_CMD_TAP_B     3
`define TRC_CMD_KEY_OFF   4
`define TRC_CMD_KEY_ON    5
`define TRC_NCMD          6
`define TRC_KEY_RET       6
`define TRC_NKEYS         7

// stat fields, read only
`define TRC_ST_TX         0
`define TRC_ST_TAP_B      1
`define TRC_ST_KEYED      2
`define TRC_ST_REMOTE     3
`define TRC_ST_LOCKOUT    4

// reset value of busst fields
`define TRC_RST_BUS       5'h00

// key debounce time and its count at the core clock
`define TRC_CLK_MHZ       200
`define TRC_DEBOUNCE_US   5000
`define TRC_DEBOUNCE_CYC  (`TRC_DEBOUNCE_US * `TRC_CLK_MHZ)
`define TRC_DB_W          20

`endif

/* File: pkg/trc_pkg.sv */
// types for the test-mode and relay control block
package trc_pkg;

   typedef enum logic {
      CTL_LOCAL,
      CTL_REMOTE
   } trc_ctl_t;

   typedef enum logic {
      MODE_RX,
      MODE_TX
   } trc_mode_t;

   // key filter state
   typedef struct packed {
      logic        meta;
      logic        sync;
      logic        level;
      logic [19:0] cnt;
      logic        press;
   } trc_filt_t;

   // control block state, outputs included
   typedef struct packed {
      trc_ctl_t    ctl;
      trc_mode_t   mode;
      logic        tap_b;
      logic        keyed;
      logic        lsn;
      logic        tlk;
      logic        srq;
      logic        lockout;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
      logic        rly_rf_rx;
      logic        rly_tap_a;
      logic        rly_tap_b;
      logic        rly_mod;
      logic        rly_mic;
      logic        rly_ana_spk;
      logic        rly_ana_demod;
      logic        rly_key;
      logic        lamp_lsn;
      logic        lamp_tlk;
      logic        lamp_srq;
      logic        lamp_rmt;
      logic        led_rx;
      logic        led_tx;
      logic        led_tap_a;
      logic        led_tap_b;
      logic        led_key_on;
      logic        led_key_off;
   } trc_state_t;

endpackage : trc_pkg

/* File: rtl/trc_key_filter.sv */
// synchroniser and debouncer for one front-panel key
`timescale 1ns/1ps
`include "trc_cfg.svh"

module trc_key_filter
   import trc_pkg::*;
#(
   parameter int unsigned CYC = `TRC_DEBOUNCE_CYC
)
(
   // clock and reset
   input  wire logic mclk_i,
   input  wire logic rst_n_i,
   // key pin, high while pressed
   input  wire logic key_i,
   // one-cycle pulse on a debounced press
   output logic      press_o
);

   localparam int W = `TRC_DB_W;

   trc_filt_t s_q;
   trc_filt_t s_d;

   always_comb
   begin
      s_d       = s_q;
      s_d.meta  = key_i;
      s_d.sync  = s_q.meta;
      s_d.press = 1'h0;
      if (s_q.sync == s_q.level)
      begin
         s_d.cnt = '0;
      end
      else if (s_q.cnt == W'(CYC - 1))
      begin
         // level held long enough, accept it
         s_d.level = s_q.sync;
         s_d.cnt   = '0;
         s_d.press = s_q.sync;
      end
      else
      begin
         s_d.cnt = W'(s_q.cnt + 1'h1);
      end
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign press_o = s_q.press;

endmodule : trc_key_filter

/* File: rtl/trc_mode_relay.sv */
// test-mode, monitor-tap, keying and bus-lamp control with apb slave
//
// Function
// RQ1 - return key moves remote operation back to local, full panel control
// RQ2 - return key ignored while local lockout is in force
// RQ3 - listener lamp lit when addressed to listener_lamp, talker lamp when talker_lamp
// RQ4 - service request lamp lit while a service request is asserted
// RQ5 - bus control lamp lit while in the remote state
// RQ6 - two tap keys choose which monitor tap gets the dut rf port
// RQ7 - dut rf port routed to a tap only while in transmit test
// RQ8 - receive test connects both rf feeds via combiner to dut rf port
// RQ9 - receive test routes audio feed input to the modulation output
// RQ10 - receive test routes speaker sense input to the analyzer output
// RQ11 - selecting receive test while keyed opens the keying relay
// RQ12 - transmit test routes dut rf port to the selected monitor tap
// RQ13 - transmit test routes audio feed input to the mic drive output
// RQ14 - transmit test routes demod feed input to the analyzer output
// RQ15 - keying off button opens the keying relay
// RQ16 - keying on button in transmit test closes the keying relay
// RQ17 - keying on button in receive test switches to transmit test
// RQ18 - after reset: receive test, tap a, indicators of active choices lit
// RQ19 - exactly one of receive or transmit test; selecting one drops other
// RQ20 - in remote, panel keys except return ignored; bus commands apply
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
`include "trc_cfg.svh"

module trc_mode_relay
   import trc_pkg::*;
#(
   parameter int unsigned DEBOUNCE_CYC = `TRC_DEBOUNCE_CYC
)
(
   // clock and reset
   input  wire logic                   mclk_i,
   input  wire logic                   rst_n_i,
   // apb slave
   input  wire logic                   psel_i,
   input  wire logic                   penable_i,
   input  wire logic                   pwrite_i,
   input  wire logic [`TRC_ADDR_W-1:0] paddr_i,
   input  wire logic [31:0]            pwdata_i,
   input  wire logic [3:0]             pstrb_i,
   output logic [31:0]                 prdata_o,
   output logic                        pready_o,
   output logic                        pslverr_o,
   // front-panel keys, high while pressed
   input  wire logic [`TRC_NKEYS-1:0]  keys_i,
   // rf relays
   output logic                        rly_rf_feed_o,
   output logic                        rly_rf_tap_a_o,
   output logic                        rly_rf_tap_b_o,
   // audio relays
   output logic                        rly_mod_out_o,
   output logic                        rly_mic_drive_o,
   output logic                        rly_ana_spk_o,
   output logic                        rly_ana_demod_o,
   // transmitter keying relay, high closes contacts
   output logic                        keying_relay_o,
   // bus status lamps
   output logic                        listener_lamp_o,
   output logic                        talker_lamp_o,
   output logic                        service_req_lamp_o,
   output logic                        bus_control_lamp_o,
   // key-cap indicators
   output logic                        led_rx_o,
   output logic                        led_tx_o,
   output logic                        led_tap_a_o,
   output logic                        led_tap_b_o,
   output logic                        led_key_on_o,
   output logic                        led_key_off_o
);

   localparam trc_state_t ST_RST = '{
      ctl         : CTL_LOCAL,
      mode        : MODE_RX,
      rly_rf_rx   : 1'h1,
      rly_mod     : 1'h1,
      rly_ana_spk : 1'h1,
      led_rx      : 1'h1,
      led_tap_a   : 1'h1,
      led_key_off : 1'h1,
      default     : '0
   };

   trc_state_t            s_q;
   trc_state_t            s_d;
   logic [`TRC_NKEYS-1:0] press;

   // one filter per panel key
   for (genvar k = 0; k < `TRC_NKEYS; k++)
   begin : g_key
      trc_key_filter #(
         .CYC     (DEBOUNCE_CYC)
      ) u_filt (
         .mclk_i  (mclk_i),
         .rst_n_i (rst_n_i),
         .key_i   (keys_i[k]),
         .press_o (press[k])
      );
   end

   always_comb
   begin
      logic                  acc;
      logic                  wr;
      logic                  mapped;
      logic                  wr_bus;
      logic                  wr_cmd;
      logic [`TRC_NCMD-1:0]  cmd;
      logic [31:0]           rd;
      trc_mode_t             mode_in;

      s_d     = s_q;
      acc     = psel_i && penable_i;
      mapped  = (paddr_i == `TRC_OFS_BUSST) ||
                (paddr_i == `TRC_OFS_CMD) ||
                (paddr_i == `TRC_OFS_STAT);
      wr      = acc && s_q.pready && pwrite_i && mapped && pstrb_i[0];
      wr_bus  = wr && (paddr_i == `TRC_OFS_BUSST);
      wr_cmd  = wr && (paddr_i == `TRC_OFS_CMD);
      rd      = '0;
      cmd     = '0;
      mode_in = s_q.mode;

      // apb: one wait state, data and answer come from flops
      s_d.pready  = 1'h0;
      s_d.pslverr = 1'h0;
      s_d.prdata  = '0;
      if (acc && !s_q.pready)
      begin
         unique case (paddr_i)
            `TRC_OFS_BUSST:
            begin
               rd[`TRC_BUS_REMOTE]  = (s_q.ctl == CTL_REMOTE);
               rd[`TRC_BUS_LISTENER_LAMP]  = s_q.lsn;
               rd[`TRC_BUS_TALKER_LAMP]    = s_q.tlk;
               rd[`TRC_BUS_SRQ]     = s_q.srq;
               rd[`TRC_BUS_LOCKOUT] = s_q.lockout;
            end
            `TRC_OFS_STAT:
            begin
               rd[`TRC_ST_TX]      = (s_q.mode == MODE_TX);
               rd[`TRC_ST_TAP_B]   = s_q.tap_b;
               rd[`TRC_ST_KEYED]   = s_q.keyed;
               rd[`TRC_ST_REMOTE]  = (s_q.ctl == CTL_REMOTE);
               rd[`TRC_ST_LOCKOUT] = s_q.lockout;
            end
            default:
            begin
               rd = '0;
            end
         endcase
         s_d.pready  = 1'h1;
         s_d.pslverr = !mapped;
         s_d.prdata  = rd;
      end

      // local/remote control; a bus write to remote beats the key
      unique case (s_q.ctl)
         CTL_LOCAL:
         begin
            cmd = press[`TRC_NCMD-1:0];
         end
         CTL_REMOTE:
         begin
            if (wr_cmd)
            begin
               cmd = pwdata_i[`TRC_NCMD-1:0];                     // RQ20
            end
            if (press[`TRC_KEY_RET] && !s_q.lockout)               // RQ2
            begin
               s_d.ctl = CTL_LOCAL;                                // RQ1
            end
         end
      endcase
      if (wr_bus)
      begin
         s_d.ctl     = pwdata_i[`TRC_BUS_REMOTE] ? CTL_REMOTE : CTL_LOCAL;
         s_d.lsn     = pwdata_i[`TRC_BUS_LISTENER_LAMP];
         s_d.tlk     = pwdata_i[`TRC_BUS_TALKER_LAMP];
         s_d.srq     = pwdata_i[`TRC_BUS_SRQ];
         s_d.lockout = pwdata_i[`TRC_BUS_LOCKOUT];
      end

      // test mode and keying; receive and keying off take priority
      if (cmd[`TRC_CMD_RX])
      begin
         s_d.mode  = MODE_RX;                                      // RQ19
         s_d.keyed = 1'h0;                                         // RQ11
      end
      else
      begin
         if (cmd[`TRC_CMD_TX])
         begin
            s_d.mode = MODE_TX;                                    // RQ19
         end
         if (cmd[`TRC_CMD_KEY_OFF])
         begin
            s_d.keyed = 1'h0;                                      // RQ15
         end
         else if (cmd[`TRC_CMD_KEY_ON])
         begin
            unique case (mode_in)
               MODE_TX:
               begin
                  s_d.keyed = 1'h1;                                // RQ16
               end
               MODE_RX:
               begin
                  s_d.mode = MODE_TX;                              // RQ17
               end
            endcase
         end
      end
      if (cmd[`TRC_CMD_TAP_A])
      begin
         s_d.tap_b = 1'h0;                                         // RQ6
      end
      else if (cmd[`TRC_CMD_TAP_B])
      begin
         s_d.tap_b = 1'h1;                                         // RQ6
      end

      // relay drive from the next state, so outputs come from flops
      s_d.rly_rf_rx     = (s_d.mode == MODE_RX);                   // RQ8
      s_d.rly_mod       = (s_d.mode == MODE_RX);                   // RQ9
      s_d.rly_ana_spk   = (s_d.mode == MODE_RX);                   // RQ10
      s_d.rly_tap_a     = (s_d.mode == MODE_TX) && !s_d.tap_b;     // RQ7 RQ12
      s_d.rly_tap_b     = (s_d.mode == MODE_TX) && s_d.tap_b;      // RQ7 RQ12
      s_d.rly_mic       = (s_d.mode == MODE_TX);                   // RQ13
      s_d.rly_ana_demod = (s_d.mode == MODE_TX);                   // RQ14
      s_d.rly_key       = (s_d.mode == MODE_TX) && s_d.keyed;      // RQ16

      // lamps and key-cap indicators
      s_d.lamp_lsn    = s_d.lsn;                                   // RQ3
      s_d.lamp_tlk    = s_d.tlk;                                   // RQ3
      s_d.lamp_srq    = s_d.srq;                                   // RQ4
      s_d.lamp_rmt    = (s_d.ctl == CTL_REMOTE);                   // RQ5
      s_d.led_rx      = (s_d.mode == MODE_RX);                     // RQ18
      s_d.led_tx      = (s_d.mode == MODE_TX);
      s_d.led_tap_a   = !s_d.tap_b;                                // RQ18
      s_d.led_tap_b   = s_d.tap_b;
      s_d.led_key_on  = s_d.rly_key;
      s_d.led_key_off = !s_d.rly_key;
   end

   always_ff @(posedge mclk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         s_q <= ST_RST;                                            // RQ18
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // apb answer
   assign prdata_o           = s_q.prdata;
   assign pready_o           = s_q.pready;
   assign pslverr_o          = s_q.pslverr;

   // relays
   assign rly_rf_feed_o      = s_q.rly_rf_rx;
   assign rly_rf_tap_a_o     = s_q.rly_tap_a;
   assign rly_rf_tap_b_o     = s_q.rly_tap_b;
   assign rly_mod_out_o      = s_q.rly_mod;
   assign rly_mic_drive_o    = s_q.rly_mic;
   assign rly_ana_spk_o      = s_q.rly_ana_spk;
   assign rly_ana_demod_o    = s_q.rly_ana_demod;
   assign keying_relay_o     = s_q.rly_key;

   // lamps
   assign listener_lamp_o    = s_q.lamp_lsn;
   assign talker_lamp_o      = s_q.lamp_tlk;
   assign service_req_lamp_o = s_q.lamp_srq;
   assign bus_control_lamp_o = s_q.lamp_rmt;

   // key-cap indicators
   assign led_rx_o           = s_q.led_rx;
   assign led_tx_o           = s_q.led_tx;
   assign led_tap_a_o        = s_q.led_tap_a;
   assign led_tap_b_o        = s_q.led_tap_b;
   assign led_key_on_o       = s_q.led_key_on;
   assign led_key_off_o      = s_q.led_key_off;

endmodule : trc_mode_relay

/* File: test/trc_mode_relay_props.sv */
// concurrent checks on the mode and relay control ports
`timescale 1ns/1ps
`include "trc_cfg.svh"
module trc_mode_relay_chk
#(
   parameter int unsigned DEBOUNCE_CYC = 4
)
(
   input wire logic                   mclk_i,
   input wire logic                   rst_n_i,
   input wire logic                   psel_i,
   input wire logic                   penable_i,
   input wire logic                   pwrite_i,
   input wire logic [`TRC_ADDR_W-1:0] paddr_i,
   input wire logic [31:0]            pwdata_i,
   input wire logic [3:0]             pstrb_i,
   input wire logic                   pready_o,
   input wire logic                   pslverr_o,
   input wire logic                   rly_rf_feed_o,
   input wire logic                   rly_rf_tap_a_o,
   input wire logic                   rly_rf_tap_b_o,
   input wire logic                   rly_mod_out_o,
   input wire logic                   rly_mic_drive_o,
   input wire logic                   rly_ana_spk_o,
   input wire logic                   rly_ana_demod_o,
   input wire logic                   keying_relay_o,
   input wire logic                   listener_lamp_o,
   input wire logic                   talker_lamp_o,
   input wire logic                   service_req_lamp_o,
   input wire logic                   bus_control_lamp_o,
   input wire logic                   led_rx_o,
   input wire logic                   led_tx_o,
   input wire logic                   led_tap_a_o,
   input wire logic                   led_tap_b_o,
   input wire logic                   led_key_on_o,
   input wire logic                   led_key_off_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!rst_n_i);
   // completed write that takes effect
   wire wr = psel_i && penable_i && pready_o && pwrite_i && pstrb_i[0];
   property p_rx_route;
      !led_tx_o |-> rly_rf_feed_o && rly_mod_out_o && rly_ana_spk_o
         && !rly_mic_drive_o && !rly_ana_demod_o;
   endproperty
   a_rx_route: assert property (p_rx_route) else $error("rx routing");
   property p_tx_route;
      led_tx_o |-> rly_mic_drive_o && rly_ana_demod_o && !rly_rf_feed_o
         && !rly_mod_out_o && !rly_ana_spk_o;
   endproperty
   a_tx_route: assert property (p_tx_route) else $error("tx routing");
   property p_tap_tx;
      rly_rf_tap_a_o || rly_rf_tap_b_o |-> led_tx_o;
   endproperty
   a_tap_tx: assert property (p_tap_tx) else $error("tap outside tx");
   property p_tap_sel;
      led_tx_o |-> rly_rf_tap_a_o == led_tap_a_o
         && rly_rf_tap_b_o == led_tap_b_o && led_tap_a_o != led_tap_b_o;
   endproperty
   a_tap_sel: assert property (p_tap_sel) else $error("tap select");
   property p_one_mode;
      led_rx_o != led_tx_o;
   endproperty
   a_one_mode: assert property (p_one_mode) else $error("mode pair");
   property p_key_tx;
      keying_relay_o |-> led_tx_o && led_key_on_o && !led_key_off_o;
   endproperty
   a_key_tx: assert property (p_key_tx) else $error("keyed in rx");
   property p_reset_st;
      $rose(rst_n_i) |-> led_rx_o && led_tap_a_o && !keying_relay_o;
   endproperty
   a_reset_st: assert property (p_reset_st) else $error("reset state");
   property p_rmt_lamp;
      wr && paddr_i == `TRC_OFS_BUSST |=>
         bus_control_lamp_o == $past(pwdata_i[0]);
   endproperty
   a_rmt_lamp: assert property (p_rmt_lamp) else $error("remote lamp");
   property p_bus_lamps;
      wr && paddr_i == `TRC_OFS_BUSST |=> {service_req_lamp_o,
         talker_lamp_o, listener_lamp_o} == $past(pwdata_i[3:1]);
   endproperty
   a_bus_lamps: assert property (p_bus_lamps) else $error("lamps");
   property p_cmd_rx;
      wr && paddr_i == `TRC_OFS_CMD && pwdata_i[0] && bus_control_lamp_o
         |=> led_rx_o && !keying_relay_o;
   endproperty
   a_cmd_rx: assert property (p_cmd_rx) else $error("bus rx");
   c_keyed: cover property (keying_relay_o);
   c_tap_b: cover property (rly_rf_tap_b_o);
   c_err: cover property (pready_o && pslverr_o);
   c_rmt: cover property (bus_control_lamp_o);
endmodule : trc_mode_relay_chk

bind trc_mode_relay trc_mode_relay_chk #(.DEBOUNCE_CYC(DEBOUNCE_CYC)) u_chk (.*);

/* File: test/trc_panel_model.sv */
// front-panel model: holds one key down for a fixed time
`timescale 1ns/1ps
module trc_panel_model
#(
   parameter int HOLD = 24
)
(
   input  wire logic       mclk_i,
   input  wire logic       go_i,
   input  wire logic [2:0] idx_i,
   output logic      [6:0] keys_o
);
   int cnt = 0;
   initial keys_o = 7'h00;
   // keys low between presses so no stray edge reaches the filter
   always @(posedge mclk_i)
   begin
      if (go_i)
      begin
         keys_o <= 7'h01 << idx_i;
         cnt <= HOLD;
      end
      else if (cnt > 1)
         cnt <= cnt - 1;
      else
         keys_o <= 7'h00;
   end
endmodule : trc_panel_model

/* File: test/tb_top.sv */
// self-checking bench for the mode and relay control block
`timescale 1ns/1ps
module tb_top;
   logic        mclk_i = 0;
   logic        rst_n_i = 0;
   logic        psel = 0, pen = 0, pwr = 0, go = 0, prdy, perr, er;
   logic [7:0]  padr = 8'h00;
   logic [31:0] pwd = 32'h0, prd, rd;
   logic [2:0]  kidx = 3'h0;
   logic [6:0]  keys;
   logic [17:0] outs;
   logic [15:0] lfsr = 16'hde5b;
   logic [4:0]  bus = 5'h00;
   logic [3:0]  pstb = 4'hf;
   int n_mismatch = 0, n_checks = 0, mode = 0, tap = 0, keyed = 0;
   int seq[$] = '{5, 5, 3, 0, 5, 2, 5, 4};

   trc_mode_relay #(.DEBOUNCE_CYC(4)) DUT (.mclk_i(mclk_i),
      .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(padr), .pwdata_i(pwd), .pstrb_i(pstb), .prdata_o(prd),
      .pready_o(prdy), .pslverr_o(perr), .keys_i(keys),
      .rly_rf_feed_o(outs[17]), .rly_rf_tap_a_o(outs[16]),
      .rly_rf_tap_b_o(outs[15]), .rly_mod_out_o(outs[14]),
      .rly_mic_drive_o(outs[13]), .rly_ana_spk_o(outs[12]),
      .rly_ana_demod_o(outs[11]), .keying_relay_o(outs[10]),
      .listener_lamp_o(outs[9]), .talker_lamp_o(outs[8]),
      .service_req_lamp_o(outs[7]), .bus_control_lamp_o(outs[6]),
      .led_rx_o(outs[5]), .led_tx_o(outs[4]), .led_tap_a_o(outs[3]),
      .led_tap_b_o(outs[2]), .led_key_on_o(outs[1]),
      .led_key_off_o(outs[0]));
   trc_panel_model u_panel (.mclk_i(mclk_i), .go_i(go), .idx_i(kidx),
      .keys_o(keys));

   initial
   begin
      forever #2.5 mclk_i = ~mclk_i;
   end

   function automatic logic [15:0] lfsr_next(logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_next

   function automatic logic [17:0] exp_v();
      logic m, t, k;
      m = mode[0];
      t = tap[0];
      k = keyed[0];
      return {!m, m & !t, m & t, !m, m, !m, m, k, bus[1], bus[2], bus[3],
         bus[0], !m, m, !t, t, k, !k};
   endfunction : exp_v

   task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask : report_and_stop

   // one apb transfer, entered just after a rising edge
   task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
      int n;
      n = 0;
      psel <= 1;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge mclk_i);
      pen <= 1;
      do
      begin
         @(posedge mclk_i);
         n++;
      end
      while (prdy !== 1'b1 && n < 20);
      rd = prd;
      er = perr;
      if (n >= 20)
         n_mismatch++;
      psel <= 0;
      pen <= 0;
   endtask : apb

   // model of one command, from keys or from the bus
   task automatic apply(int c);
      if (c == 0 || c == 4)
         keyed = 0;
      if (c == 5)
         keyed = mode;
      if (c == 0)
         mode = 0;
      if (c == 1 || c == 5)
         mode = 1;
      if (c == 2 || c == 3)
         tap = c - 2;
   endtask : apply

   task automatic press(int k);
      kidx <= 3'(k);
      go <= 1;
      @(posedge mclk_i);
      go <= 0;
      repeat (60) @(posedge mclk_i);
      if (k < 6 && !bus[0])
         apply(k);
      if (k == 6 && !bus[4])
         bus[0] = 0;
      chk("key", outs, exp_v());
   endtask : press

   task automatic busst(logic [4:0] v);
      apb(1, 8'h00, {27'h0, v});
      bus = v;
      @(posedge mclk_i);
      chk("busst", outs, exp_v());
   endtask : busst

   initial
   begin
      repeat (3) @(posedge mclk_i);
      rst_n_i <= 1;
      @(posedge mclk_i);
      chk("reset", outs, exp_v());
      foreach (seq[i])
         press(seq[i]);
      press(0);
      press(1);
      for (int i = 0; i < 10; i++)
      begin
         lfsr = lfsr_next(lfsr);
         press(lfsr % 6);
      end
      busst(lfsr[4:0] & 5'h0f | 5'h01);
      press(1);
      foreach (seq[i])
      begin
         apb(1, 8'h04, 32'h1 << seq[i]);
         apply(seq[i]);
         @(posedge mclk_i);
         chk("bus cmd", outs, exp_v());
      end
      apb(0, 8'h08, 32'h0);
      chk("stat", rd, {bus[4:0] & 5'h10 | {1'b0, bus[0], keyed[0], tap[0],
         mode[0]}});
      apb(0, 8'h00, 32'h0);
      chk("busst rd", rd, {27'h0, bus});
      apb(0, 8'h0c, 32'h0);
      chk("unmapped", {31'h0, er}, 32'h1);
      busst(5'h13);
      press(6);
      busst(5'h01);
      press(6);
      apb(1, 8'h04, 32'h2);
      @(posedge mclk_i);
      chk("local cmd", outs, exp_v());
      pstb <= 4'h0;
      apb(1, 8'h00, 32'h1f);
      pstb <= 4'hf;
      @(posedge mclk_i);
      chk("strobe", outs, exp_v());
      report_and_stop();
   end

   initial
   begin
      repeat (20000) @(posedge mclk_i);
      n_mismatch++;
      report_and_stop();
   end
endmodule : tb_top
